// ==== hw/ptes_top.sv ====
/*
  PWM timer event-B input, interrupt flags, activity and sync
  status, fault response decode, behind an Avalon-MM slave.
  Assumes the timer core runs on clk_sys, presents its events as
  one-cycle pulses in ptes_timer_in_t, and the event pin is async.
*/
// Added by the designer: register access over Avalon-MM.
module ptes_top #(
  parameter int SYNC_LAT = ptes_pkg::SYNC_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Timer core side
  input wire logic event_b_pin,
  input wire ptes_pkg::ptes_timer_in_t timer_in,
  output ptes_pkg::ptes_cmd_t timer_cmd,
  output logic timer_enable,
  output ptes_pkg::ptes_evt_out_t event_b_out,
  output ptes_pkg::ptes_fault_resp_t resp_a,
  output ptes_pkg::ptes_fault_resp_t resp_b,
  // Interrupt
  output logic irq
);

  // Latency counters are four bits wide, so the value must fit
  if (SYNC_LAT < 1 || SYNC_LAT > 15)
  begin : g_lat_check
    $error("SYNC_LAT must lie in 1..15");
  end

  // Maps a mode code to its response; unlisted codes do nothing
  function automatic ptes_pkg::ptes_fault_resp_t decode_mode(
    input logic [3:0] m
  );
    ptes_pkg::ptes_fault_resp_t r;
    r = ptes_pkg::RESP_NONE;
    unique case (m)
      4'h1: r = ptes_pkg::RESP_JUMP_OPP_HOLD;
      4'h2: r = ptes_pkg::RESP_RUN_OPP_HOLD;
      4'h3: r = ptes_pkg::RESP_RUN_OPP_FAULT;
      4'h4: r = ptes_pkg::RESP_HALT_ALL_KEEP_PERIOD;
      4'h5: r = ptes_pkg::RESP_DEADTIME_FAULT;
      4'h6: r = ptes_pkg::RESP_HALT_ALL_NEXT_HOLD;
      4'h7: r = ptes_pkg::RESP_HALT_UNTIL_SW;
      4'h8: r = ptes_pkg::RESP_EDGE_STOP_NEXT;
      4'h9: r = ptes_pkg::RESP_EDGE_STOP_KEEP_PERIOD;
      4'hA: r = ptes_pkg::RESP_LEVEL_STOP_KEEP_PERIOD;
      default: r = ptes_pkg::RESP_NONE;
    endcase
    return r;
  endfunction : decode_mode

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] idx;
  logic wr_go;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  logic [7:0] evb_r, evb_nxt, irqen_r, irqen_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic [1:0] act_r, act_nxt;
  logic [3:0] mode_a_r, mode_a_nxt, mode_b_r, mode_b_nxt;
  logic auto_r, auto_nxt, dbg_run_r, dbg_run_nxt;
  logic enable_r, enable_nxt;
  logic cmd_rdy_r, cmd_rdy_nxt, en_rdy_r, en_rdy_nxt;

  assign idx = address[7:2];
  assign wbyte = writedata[7:0];
  // A write lands at the edge where waitrequest is seen low
  assign wr_go = write && !wait_r;

  // Read mux; unmapped indices read as zero
  always_comb
  begin
    rbyte = 8'h00;
    unique case (idx)
      ptes_pkg::IDX_ENABLE: rbyte = {7'h00, enable_r};
      ptes_pkg::IDX_AUTO: rbyte = {6'h00, auto_r, 1'b0};
      ptes_pkg::IDX_EVB: rbyte = evb_r;
      ptes_pkg::IDX_IRQEN: rbyte = irqen_r;
      ptes_pkg::IDX_FLAGS: rbyte = flags_r;
      ptes_pkg::IDX_STATUS:
        rbyte = {act_r, 4'h0, cmd_rdy_r, en_rdy_r};
      ptes_pkg::IDX_INA: rbyte = {4'h0, mode_a_r};
      ptes_pkg::IDX_INB: rbyte = {4'h0, mode_b_r};
      ptes_pkg::IDX_DBG: rbyte = {7'h00, dbg_run_r};
      default: rbyte = 8'h00;
    endcase
  end

  // One wait cycle per request, then a single ready cycle
  always_comb
  begin
    wait_nxt = !((read || write) && wait_r);
    rdata_nxt = rdata_r;
    if (read && wait_r)
      rdata_nxt = {24'h000000, rbyte};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign waitrequest = wait_r;
  assign readdata = rdata_r;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb
  begin
    evb_nxt = evb_r;
    irqen_nxt = irqen_r;
    mode_a_nxt = mode_a_r;
    mode_b_nxt = mode_b_r;
    auto_nxt = auto_r;
    dbg_run_nxt = dbg_run_r;
    if (wr_go)
    begin
      unique case (idx)
        ptes_pkg::IDX_EVB: evb_nxt = wbyte & ptes_pkg::EVB_MASK;
        ptes_pkg::IDX_IRQEN:
          irqen_nxt = wbyte & ptes_pkg::IRQ_MASK;
        ptes_pkg::IDX_INA: mode_a_nxt = wbyte[3:0];
        ptes_pkg::IDX_INB: mode_b_nxt = wbyte[3:0];
        ptes_pkg::IDX_AUTO: auto_nxt = wbyte[ptes_pkg::AUTO_BIT];
        ptes_pkg::IDX_DBG: dbg_run_nxt = wbyte[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      evb_r <= ptes_pkg::RST_BYTE;
      irqen_r <= ptes_pkg::RST_BYTE;
      mode_a_r <= 4'h0;
      mode_b_r <= 4'h0;
      auto_r <= 1'b0;
      dbg_run_r <= 1'b0;
    end
    else
    begin
      evb_r <= evb_nxt;
      irqen_r <= irqen_nxt;
      mode_a_r <= mode_a_nxt;
      mode_b_r <= mode_b_nxt;
      auto_r <= auto_nxt;
      dbg_run_r <= dbg_run_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Event B input path
  // ---------------------------------------------------------------
  logic ev_s1_r, ev_s2_r, stage_r, filt_r, filt_nxt, prev_r;
  logic [ptes_pkg::FILTER_LEN-1:0] hist_r;
  logic [1:0] cfg;
  logic qual, active, rise, trig_en;
  ptes_pkg::ptes_evt_out_t evo_r, evo_nxt;

  assign cfg = evb_r[ptes_pkg::EVB_CFG_LSB +: 2];
  assign trig_en = evb_r[ptes_pkg::EVB_TRIG];

  // Filter flips only once the whole history agrees
  always_comb
  begin
    filt_nxt = filt_r;
    if (&hist_r)
      filt_nxt = 1'b1;
    else if (~|hist_r)
      filt_nxt = 1'b0;
  end

  // Path choice; the filter costs four more edges than plain
  always_comb
  begin
    unique case (cfg)
      ptes_pkg::CFG_FILT: qual = filt_r;
      ptes_pkg::CFG_ASYNC: qual = ev_s2_r;
      default: qual = stage_r;
    endcase
    active = evb_r[ptes_pkg::EVB_EDGE] ? qual : !qual;
    rise = active && !prev_r;
    evo_nxt.fault_level = trig_en && active;
    evo_nxt.fault_pulse = trig_en && rise;
    evo_nxt.capture_pulse =
      trig_en && rise && evb_r[ptes_pkg::EVB_ACTION];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      stage_r <= 1'b0;
      hist_r <= '0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
      evo_r <= '0;
    end
    else
    begin
      ev_s1_r <= event_b_pin;
      ev_s2_r <= ev_s1_r;
      stage_r <= ev_s2_r;
      hist_r <= {hist_r[ptes_pkg::FILTER_LEN-2:0], ev_s2_r};
      filt_r <= filt_nxt;
      prev_r <= active;
      evo_r <= evo_nxt;
    end
  end

  assign event_b_out = evo_r;

  // ---------------------------------------------------------------
  // Flags, activity and interrupt line
  // ---------------------------------------------------------------
  logic [7:0] flag_set, flag_clr;
  logic [1:0] wave_prev_r, act_set, act_clr;
  logic irq_r, irq_nxt;

  // Set beats a clear arriving in the same cycle
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[ptes_pkg::IRQ_INPUT_B_TRIGGER_IRQ] = evo_nxt.fault_pulse
      || timer_in.cap_b;
    flag_set[ptes_pkg::IRQ_INPUT_A_TRIGGER_IRQ] = timer_in.trig_a
      || timer_in.cap_a;
    flag_set[ptes_pkg::IRQ_OVF] = timer_in.cycle_end;
    flag_clr = 8'h00;
    if (wr_go && idx == ptes_pkg::IDX_FLAGS)
      flag_clr = wbyte & ptes_pkg::IRQ_MASK;
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    act_set = {timer_in.wave_b ^ wave_prev_r[1],
               timer_in.wave_a ^ wave_prev_r[0]};
    act_clr = 2'b00;
    if (wr_go && idx == ptes_pkg::IDX_STATUS)
      act_clr = {wbyte[ptes_pkg::ST_ACTB], wbyte[ptes_pkg::ST_ACTA]};
    act_nxt = (act_r & ~act_clr) | act_set;
    irq_nxt = |(flags_nxt & irqen_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      flags_r <= ptes_pkg::RST_BYTE;
      act_r <= 2'b00;
      wave_prev_r <= 2'b00;
      irq_r <= 1'b0;
    end
    else
    begin
      flags_r <= flags_nxt;
      act_r <= act_nxt;
      wave_prev_r <= {timer_in.wave_b, timer_in.wave_a};
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ---------------------------------------------------------------
  // Command and enable handshakes into the timer
  // ---------------------------------------------------------------
  logic [3:0] cmd_cnt_r, cmd_cnt_nxt, en_cnt_r, en_cnt_nxt;
  ptes_pkg::ptes_cmd_t pend_r, pend_nxt, cmd_r, cmd_nxt, strobes;
  logic cmd_wr, cmpbh_wr, new_cmd, en_wr, dis_wr, brk;
  logic dis_pend_r, dis_pend_nxt, ten_r, ten_nxt;
  logic [3:0] lat;

  assign lat = 4'(SYNC_LAT);
  assign cmd_wr = wr_go && idx == ptes_pkg::IDX_CMD;
  assign strobes = ptes_pkg::ptes_cmd_t'(
    {wbyte[0], wbyte[1], wbyte[2], wbyte[3], wbyte[4]});
  assign cmpbh_wr = wr_go && idx == ptes_pkg::IDX_CMPBH && auto_r;
  // A strobe while busy is dropped, so software polls first
  assign new_cmd = cmd_rdy_r
    && ((cmd_wr && |strobes) || cmpbh_wr);
  assign en_wr = wr_go && idx == ptes_pkg::IDX_ENABLE;
  assign dis_wr = cmd_wr && wbyte[ptes_pkg::CMD_DIS_EOC] && en_rdy_r;
  assign brk = timer_in.dbg_break && !dbg_run_r;

  // Command crossing: latency count, then one-cycle strobe
  always_comb
  begin
    cmd_rdy_nxt = cmd_rdy_r;
    cmd_cnt_nxt = cmd_cnt_r;
    pend_nxt = pend_r;
    cmd_nxt = '0;
    if (new_cmd)
    begin
      pend_nxt = strobes;
      pend_nxt.sync_eoc = strobes.sync_eoc || cmpbh_wr;
      cmd_cnt_nxt = lat;
      cmd_rdy_nxt = 1'b0;
    end
    else if (!cmd_rdy_r)
    begin
      cmd_cnt_nxt = cmd_cnt_r - 4'h1;
      if (cmd_cnt_r == 4'h1)
      begin
        cmd_rdy_nxt = 1'b1;
        cmd_nxt = pend_r;
      end
    end
  end

  // Enable crossing; disable-at-end holds ready low till cycle end, then for the latency count
  always_comb
  begin
    enable_nxt = enable_r;
    en_rdy_nxt = en_rdy_r;
    en_cnt_nxt = en_cnt_r;
    dis_pend_nxt = dis_pend_r;
    ten_nxt = ten_r;
    if (en_wr || brk)
    begin
      if (en_wr)
        enable_nxt = wbyte[0];
      en_rdy_nxt = 1'b0;
      en_cnt_nxt = lat;
    end
    else if (dis_wr)
    begin
      dis_pend_nxt = 1'b1;
      en_rdy_nxt = 1'b0;
    end
    else if (dis_pend_r)
    begin
      if (timer_in.cycle_end)
      begin
        dis_pend_nxt = 1'b0;
        enable_nxt = 1'b0;
        ten_nxt = 1'b0;
        en_cnt_nxt = lat;
      end
    end
    else if (!en_rdy_r)
    begin
      en_cnt_nxt = en_cnt_r - 4'h1;
      if (en_cnt_r == 4'h1)
      begin
        en_rdy_nxt = 1'b1;
        ten_nxt = enable_r;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmd_rdy_r <= 1'b0;
      cmd_cnt_r <= 4'(ptes_pkg::SYNC_CYCLES);
      pend_r <= '0;
      cmd_r <= '0;
      enable_r <= 1'b0;
      en_rdy_r <= 1'b0;
      en_cnt_r <= 4'(ptes_pkg::SYNC_CYCLES);
      dis_pend_r <= 1'b0;
      ten_r <= 1'b0;
    end
    else
    begin
      cmd_rdy_r <= cmd_rdy_nxt;
      cmd_cnt_r <= cmd_cnt_nxt;
      pend_r <= pend_nxt;
      cmd_r <= cmd_nxt;
      enable_r <= enable_nxt;
      en_rdy_r <= en_rdy_nxt;
      en_cnt_r <= en_cnt_nxt;
      dis_pend_r <= dis_pend_nxt;
      ten_r <= ten_nxt;
    end
  end

  assign timer_cmd = cmd_r;
  assign timer_enable = ten_r;

  // ---------------------------------------------------------------
  // Fault response decode
  // ---------------------------------------------------------------
  ptes_pkg::ptes_fault_resp_t ra_r, ra_nxt, rb_r, rb_nxt;

  // Registered so the timer sees a clean code
  always_comb
  begin
    ra_nxt = decode_mode(mode_a_r);
    rb_nxt = decode_mode(mode_b_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ra_r <= ptes_pkg::RESP_NONE;
      rb_r <= ptes_pkg::RESP_NONE;
    end
    else
    begin
      ra_r <= ra_nxt;
      rb_r <= rb_nxt;
    end
  end

  assign resp_a = ra_r;
  assign resp_b = rb_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_cmd_busy;
    !cmd_rdy_r [*4] ##1 cmd_rdy_r;
  endsequence

  property p_ovf_set;
    timer_in.cycle_end |=> flags_r[0];
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("cycle end did not set overflow flag");

  property p_w1c;
    wr_go && idx == ptes_pkg::IDX_FLAGS && wbyte[0]
      && !timer_in.cycle_end |=> !flags_r[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("written one did not clear flag");

  property p_w0_keep;
    flags_r[2] && !(wr_go && idx == ptes_pkg::IDX_FLAGS
      && wbyte[2]) |=> flags_r[2];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("flag lost without a written one");

  property p_irq;
    flags_r[3] && irqen_r[3] ##1 flags_r[3] |-> irq_r;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq low with enabled flag set");

  property p_cmd_sync;
    new_cmd && SYNC_LAT == 4 |=> s_cmd_busy;
  endproperty
  a_cmd_sync: assert property (p_cmd_sync)
    else $error("command ready timing wrong");

  property p_cmd_drop;
    cmd_wr && !cmd_rdy_r |=> pend_r == $past(pend_r);
  endproperty
  a_cmd_drop: assert property (p_cmd_drop)
    else $error("strobe accepted while busy");

  property p_filter;
    $changed(filt_r) |-> $past(hist_r) == {4{filt_r}};
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter moved without four samples");

  property p_act;
    timer_in.wave_a != wave_prev_r[0] |=> act_r[0] [*1];
  endproperty
  a_act: assert property (p_act)
    else $error("toggle did not set activity");

  property p_act_hold;
    act_r[1] && !(wr_go && idx == ptes_pkg::IDX_STATUS
      && wbyte[7]) |=> act_r[1];
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("activity bit dropped on its own");

  property p_en_clr;
    en_wr |=> !en_rdy_r ##1 !en_rdy_r;
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("enable write left ready high");

endmodule : ptes_top

// ==== hw/ptes_pkg.sv ====
/*
  Package for the PWM timer event, interrupt and status block:
  register indices, field positions, reset values, codes and the
  structs that carry timer-side signals.
  Assumes one clock domain and a byte-wide register file whose
  byte address on the bus is four times the index.
*/
package ptes_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is index times four)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_ENABLE = 6'h00;
  localparam logic [5:0] IDX_AUTO = 6'h02;
  localparam logic [5:0] IDX_CMD = 6'h04;
  localparam logic [5:0] IDX_EVB = 6'h09;
  localparam logic [5:0] IDX_IRQEN = 6'h0C;
  localparam logic [5:0] IDX_FLAGS = 6'h0D;
  localparam logic [5:0] IDX_STATUS = 6'h0E;
  localparam logic [5:0] IDX_INA = 6'h10;
  localparam logic [5:0] IDX_INB = 6'h11;
  localparam logic [5:0] IDX_DBG = 6'h1E;
  localparam logic [5:0] IDX_CMPBH = 6'h2F;

  // ---------------------------------------------------------------
  // Field positions and writable masks
  // ---------------------------------------------------------------
  localparam int EVB_CFG_LSB = 6;
  localparam int EVB_EDGE = 4;
  localparam int EVB_ACTION = 2;
  localparam int EVB_TRIG = 0;
  localparam logic [7:0] EVB_MASK = 8'hD5;
  localparam int IRQ_INPUT_B_TRIGGER_IRQ = 3;
  localparam int IRQ_INPUT_A_TRIGGER_IRQ = 2;
  localparam int IRQ_OVF = 0;
  localparam logic [7:0] IRQ_MASK = 8'h0D;
  localparam int ST_ACTB = 7;
  localparam int ST_ACTA = 6;
  localparam int ST_CMD = 1;
  localparam int ST_EN = 0;
  localparam int CMD_DIS_EOC = 7;
  localparam int AUTO_BIT = 1;
  localparam logic [7:0] MODE_MASK = 8'h0F;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ---------------------------------------------------------------
  // Codes and timing
  // ---------------------------------------------------------------
  localparam logic [1:0] CFG_NONE = 2'h0;
  localparam logic [1:0] CFG_FILT = 2'h1;
  localparam logic [1:0] CFG_ASYNC = 2'h2;
  localparam int FILTER_LEN = 4;
  localparam int SYNC_NS = 20;
  localparam int CLK_NS = 5;
  localparam int SYNC_CYCLES = (SYNC_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RESP_NONE, RESP_JUMP_OPP_HOLD, RESP_RUN_OPP_HOLD,
    RESP_RUN_OPP_FAULT, RESP_HALT_ALL_KEEP_PERIOD,
    RESP_DEADTIME_FAULT, RESP_HALT_ALL_NEXT_HOLD,
    RESP_HALT_UNTIL_SW, RESP_EDGE_STOP_NEXT,
    RESP_EDGE_STOP_KEEP_PERIOD, RESP_LEVEL_STOP_KEEP_PERIOD
  } ptes_fault_resp_t;

  typedef struct packed {
    logic cycle_end;
    logic trig_a;
    logic cap_a;
    logic cap_b;
    logic wave_a;
    logic wave_b;
    logic dbg_break;
  } ptes_timer_in_t;

  typedef struct packed {
    logic sync_eoc;
    logic sync_now;
    logic restart;
    logic cap_a;
    logic cap_b;
  } ptes_cmd_t;

  typedef struct packed {
    logic fault_level;
    logic fault_pulse;
    logic capture_pulse;
  } ptes_evt_out_t;

endpackage : ptes_pkg

// ==== testbench/ptes_partner.sv ====
/*
  Partner model: event routing network and timer core around the
  block, drives the event B pin and the timer-side inputs.
  Assumes the bench calls its tasks from the clk_sys domain.
*/
module ptes_partner (
  // Clock
  input wire logic clk_sys,
  // Event pin and timer core
  output logic event_b_pin,
  output ptes_pkg::ptes_timer_in_t timer_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels from time zero
  initial
  begin
    event_b_pin = 1'b0;
    timer_in = '0;
  end

  // Core events are single-cycle pulses, never stretched
  task automatic pulse(input int b);
    @(posedge clk_sys);
    timer_in[b] <= 1'b1;
    @(posedge clk_sys);
    timer_in[b] <= 1'b0;
  endtask : pulse

  // Waveform output changes level once
  task automatic toggle(input int b);
    @(posedge clk_sys);
    timer_in[b] <= ~timer_in[b];
    @(posedge clk_sys);
  endtask : toggle

  // Event pin level, moved just after an edge
  task automatic pin(input logic v);
    @(posedge clk_sys);
    event_b_pin <= v;
  endtask : pin
endmodule : ptes_partner

// ==== testbench/test_pwm_timer_event_irq_status.sv ====
/*
  Self-checking bench for ptes_top: register access, flags, activity,
  sync status, fault mode decode and event B qualification.
  Assumes the partner model in ptes_partner and SYNC_LAT of 4.
*/
module test_pwm_timer_event_irq_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic sys_rst;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic event_b_pin;
  ptes_pkg::ptes_timer_in_t timer_in;
  ptes_pkg::ptes_cmd_t timer_cmd;
  logic timer_enable;
  ptes_pkg::ptes_evt_out_t event_b_out;
  ptes_pkg::ptes_fault_resp_t resp_a;
  ptes_pkg::ptes_fault_resp_t resp_b;
  logic irq;
  logic [4:0] cmd_seen;
  logic seen_clr;
  int fp_cnt;
  int errors;
  int samples_checked;
  int p;
  int f;
  int q;
  logic c;
  localparam logic [5:0] REGS [6] = '{6'h09, 6'h0C, 6'h0D, 6'h10,
    6'h11, 6'h3F};
  localparam int PB [4] = '{5, 4, 3, 6};
  localparam logic [7:0] FL [4] = '{8'h04, 8'h04, 8'h08, 8'h01};

  ptes_top #(.SYNC_LAT(4)) ptes_top_i (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .event_b_pin(event_b_pin),
    .timer_in(timer_in),
    .timer_cmd(timer_cmd),
    .timer_enable(timer_enable),
    .event_b_out(event_b_out),
    .resp_a(resp_a),
    .resp_b(resp_b),
    .irq(irq)
  );
  ptes_partner ptes_partner_i (
    .clk_sys(clk_sys),
    .event_b_pin(event_b_pin),
    .timer_in(timer_in)
  );

  // 200 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Sticky record of command pulses; count of fault pulses
  // Only this process writes them, so a clear never races a pulse
  always @(posedge clk_sys)
  begin
    if (sys_rst || seen_clr)
      cmd_seen <= 5'h00;
    else
      cmd_seen <= cmd_seen | timer_cmd;
    if (sys_rst)
      fp_cnt <= 0;
    else
      fp_cnt <= fp_cnt + int'(event_b_out.fault_pulse === 1'b1);
  end

  // Hang guard, far above the under a thousand cycles needed
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Command record cleared across one whole clock edge
  task automatic clear_seen();
    seen_clr = 1'b1;
    tick(1);
    seen_clr = 1'b0;
  endtask : clear_seen

  // Request held until waitrequest is sampled low, released there
  task automatic bus(input logic wr, input logic [5:0] idx,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= {idx, 2'h0};
    writedata <= {24'h0, wd};
    read <= ~wr;
    write <= wr;
    do
    begin
      tick(1);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      errors++;
    rd = readdata[7:0];
    @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    logic [7:0] x;
    bus(1'b1, idx, v, x);
  endtask : wr

  task automatic rdc(input logic [5:0] idx, input logic [7:0] m,
    input logic [7:0] exp);
    logic [7:0] x;
    bus(1'b0, idx, 8'h00, x);
    check(x & m, exp);
  endtask : rdc

  // Software polls the ready bit before the next strobe
  task automatic wait_rdy(input int b);
    logic [7:0] x;
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 6'h0E, 8'h00, x);
      n++;
    end
    while (x[b] !== 1'b1 && n < 20);
    check({7'h0, x[b]}, 8'h01);
  endtask : wait_rdy

  // Cycles from pin reaching lvl to the fault pulse
  task automatic ev(input logic [7:0] cfg, input logic lvl,
    output int n, output logic cap);
    wr(6'h09, cfg);
    ptes_partner_i.pin(~lvl);
    tick(10);
    ptes_partner_i.pin(lvl);
    n = 0;
    cap = 1'b0;
    do
    begin
      tick(1);
      n++;
      cap = cap | (event_b_out.capture_pulse === 1'b1);
    end
    while (event_b_out.fault_pulse !== 1'b1 && n < 30);
  endtask : ev

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    seen_clr = 1'b0;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    foreach (REGS[i]) rdc(REGS[i], 8'hFF, 8'h00);
    wait_rdy(1);
    wait_rdy(0);
    wr(6'h09, 8'hFF);
    rdc(6'h09, 8'hFF, 8'hD5);
    wr(6'h0C, 8'hFF);
    rdc(6'h0C, 8'hFF, 8'h0D);
    // Each timer-side flag source, with its enable off then on
    for (int i = 0; i < 4; i++)
    begin
      wr(6'h0C, FL[i] ^ 8'h0D);
      ptes_partner_i.pulse(PB[i]);
      rdc(6'h0D, 8'hFF, FL[i]);
      check({7'h0, irq}, 8'h00);
      wr(6'h0D, 8'h00);
      wr(6'h0C, FL[i]);
      tick(2);
      check({7'h0, irq}, 8'h01);
      rdc(6'h0D, 8'hFF, FL[i]);
      wr(6'h0D, FL[i]);
      rdc(6'h0D, 8'hFF, 8'h00);
      tick(2);
      check({7'h0, irq}, 8'h00);
    end
    // Activity bits are sticky until a one is written
    ptes_partner_i.toggle(2);
    rdc(6'h0E, 8'hC0, 8'h40);
    ptes_partner_i.toggle(2);
    wr(6'h0E, 8'h00);
    rdc(6'h0E, 8'hC0, 8'h40);
    wr(6'h0E, 8'h40);
    rdc(6'h0E, 8'hC0, 8'h00);
    ptes_partner_i.toggle(1);
    rdc(6'h0E, 8'hC0, 8'h80);
    wr(6'h0E, 8'h80);
    rdc(6'h0E, 8'hC3, 8'h03);
    // Every strobe; a second one during the crossing is dropped
    for (int k = 0; k < 5; k++)
    begin
      clear_seen();
      wr(6'h04, 8'(1 << k));
      if (k == 0)
        wr(6'h04, 8'h02);
      else
        rdc(6'h0E, 8'h02, 8'h00);
      wait_rdy(1);
      tick(10);
      check({3'h0, cmd_seen}, 8'(5'h10 >> k));
    end
    wr(6'h02, 8'h02);
    clear_seen();
    wr(6'h2F, 8'h00);
    rdc(6'h0E, 8'h02, 8'h00);
    wait_rdy(1);
    check({3'h0, cmd_seen}, 8'h10);
    wr(6'h02, 8'h00);
    // Enable crossing, disable at cycle end, debug break
    wr(6'h00, 8'h01);
    rdc(6'h0E, 8'h01, 8'h00);
    wait_rdy(0);
    check({7'h0, timer_enable}, 8'h01);
    wr(6'h04, 8'h80);
    tick(20);
    rdc(6'h0E, 8'h01, 8'h00);
    ptes_partner_i.pulse(6);
    wait_rdy(0);
    check({7'h0, timer_enable}, 8'h00);
    ptes_partner_i.pulse(0);
    rdc(6'h0E, 8'h01, 8'h00);
    wait_rdy(0);
    wr(6'h1E, 8'h01);
    ptes_partner_i.pulse(0);
    rdc(6'h0E, 8'h01, 8'h01);
    // All sixteen mode codes on both inputs
    for (int m = 0; m < 16; m++)
    begin
      wr(6'h10, 8'(m) | 8'hF0);
      wr(6'h11, 8'(15 - m));
      tick(3);
      check({4'h0, resp_a}, m < 11 ? 8'(m) : 8'h00);
      check({4'h0, resp_b}, m > 4 ? 8'(15 - m) : 8'h00);
      rdc(6'h10, 8'hFF, 8'(m));
    end
    // Event B: plain, filtered, async, falling, fault only
    ev(8'h15, 1'b1, p, c);
    check({7'h0, c}, 8'h01);
    ev(8'h55, 1'b1, f, c);
    check(8'(f), 8'(p + 4));
    ev(8'h95, 1'b1, f, c);
    check(8'(f), 8'(p - 1));
    ev(8'h01, 1'b0, q, c);
    check(8'(q), 8'(p));
    check({7'h0, c}, 8'h00);
    check({7'h0, event_b_out.fault_level}, 8'h01);
    wr(6'h0D, 8'h0D);
    ev(8'h10, 1'b1, q, c);
    rdc(6'h0D, 8'h08, 8'h00);
    check({7'h0, event_b_out.fault_level}, 8'h00);
    ev(8'h11, 1'b1, q, c);
    rdc(6'h0D, 8'h08, 8'h08);
    check({7'h0, event_b_out.fault_level}, 8'h01);
    // Three-sample glitch must not pass the filter
    wr(6'h09, 8'h51);
    ptes_partner_i.pin(1'b0);
    tick(10);
    f = fp_cnt;
    ptes_partner_i.pin(1'b1);
    tick(2);
    ptes_partner_i.pin(1'b0);
    tick(15);
    check(8'(fp_cnt - f), 8'h00);
    end_of_test();
  end
endmodule : test_pwm_timer_event_irq_status
